// [rtl/host_regs_consts.svh]
`ifndef HOST_REGS_CONSTS_SVH
`define HOST_REGS_CONSTS_SVH

// Register offsets inside the 8KB window
`define ADDR_W 13
`define DEVICE_CONFIGURATION_OFS 13'h100a
`define INTERRUPT_CONTROL_OFS 13'h100e
`define PRESENCE_TOGGLE_OFS 13'h1046

// Device configuration fields
`define CFG_STRAP_BIT 7
`define CFG_INDEX_LO 4
`define CFG_INDEX_HI 5
`define CFG_LOW_NIBBLE 4'h2
`define CFG_INDEX_RESET 2'h0
`define CFG_RSVD_BIT 6

// Interrupt control fields
`define TRIG_OFF 3'h0
`define TRIG_ON_READY 3'h1
`define ICTL_VIOL_FLAG_BIT 6
`define ICTL_READY_FLAG_BIT 5
`define ICTL_CTRL_HI 4

// Presence toggle fields
`define TOGGLE_FIXED 8'h82
`define TOGGLE_BIT 2

`define READ_IDLE 8'h00
`define SYNC_RESET_BUS 24'he0_0000

`endif

// [rtl/host_regs_pkg.sv]
package host_regs_pkg;

  // Host memory bus pins as seen by the device
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [12:0] addr;
    logic [7:0] data;
  } host_bus_t;

  // Software-written part of the interrupt control register
  typedef struct packed {
    logic pulse_mode;
    logic violation_trigger_enable;
    logic [2:0] ready_trigger_select;
  } irq_ctrl_t;

  // Interrupt unit state returned to the register file
  typedef struct packed {
    logic violation_flag;
    logic ready_flag;
  } irq_flags_t;

endpackage

// [rtl/irq_event_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "host_regs_consts.svh"

module irq_event_unit
  import host_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire irq_ctrl_t ctrl_in,
  input wire logic clear_ready_in,
  input wire logic clear_violation_in,
  // Events
  input wire logic flash_ready_in,
  input wire logic prot_violation_in,
  // State
  output var irq_flags_t flags_out,
  output logic irq_n_out
);

  logic ready_prev_r;
  irq_flags_t flags_r;
  irq_flags_t flags_nxt;
  logic irq_n_r;
  logic irq_n_nxt;

  wire trig_off = (ctrl_in.ready_trigger_select == `TRIG_OFF);
  wire ready_rise = flash_ready_in & ~ready_prev_r;
  wire ready_event = ready_rise & (ctrl_in.ready_trigger_select == `TRIG_ON_READY);
  wire viol_event = prot_violation_in & ctrl_in.violation_trigger_enable;
  wire new_set = (ready_event & ~flags_r.ready_flag) | (viol_event & ~flags_r.violation_flag);

  // A set arriving with its clear keeps the flag up
  assign flags_nxt.ready_flag = ready_event | (flags_r.ready_flag & ~clear_ready_in);
  assign flags_nxt.violation_flag = viol_event | (flags_r.violation_flag & ~clear_violation_in);

  // Pulse mode gives one low cycle after each cycle that newly sets either flag, unless the trigger is 000
  assign irq_n_nxt = trig_off ? 1'b1 :
                     ctrl_in.pulse_mode ? ~new_set :
                     ~(flags_nxt.ready_flag | flags_nxt.violation_flag);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_prev_r <= 1'b0;
      flags_r <= '0;
      irq_n_r <= 1'b1;
    end else begin
      ready_prev_r <= flash_ready_in;
      flags_r <= flags_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  assign flags_out = flags_r;
  assign irq_n_out = irq_n_r;

endmodule

`default_nettype wire

// [rtl/host_config_irq_registers.sv]
// What this block does
// - Configuration bits reset only by hardware reset
// - Bit 7 reads live bus-width strap pin
// - Cascade index field steers boot-block mapping
// - Two sources: flash ready, protection violation
// - Trigger 000 disables ready, holds output negated
// - Trigger 001 interrupts when flash becomes ready
// - Violation enable raises interrupt on violation unless trigger is 000
// - Level mode holds output until flag cleared
// - Pulse mode signals low-going pulse instead
// - Ready flag set on ready interrupt; W1C
// - Violation flag set on enabled violation; W1C
// - Toggle bit inverts on each read in Normal mode
// - Reserved-zero bits read zero
// - Reserved-one bits read one
// - Reads return zero outside Normal mode
`timescale 1ns/1ps
`default_nettype none
`include "host_regs_consts.svh"

module host_config_irq_registers
  import host_regs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Host memory bus
  input wire host_bus_t bus_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // Straps and cascade pins
  input wire logic if_width_strap_in,
  input wire logic [1:0] cascade_select_inputs_in,
  // Device state and events, same clock
  input wire logic normal_mode_in,
  input wire logic flash_ready_in,
  input wire logic prot_violation_in,
  // Interrupt and boot mapping
  output logic irq_n_out,
  output logic [1:0] highest_cascade_index_out,
  output logic boot_block_mapped_out
);

  // Reset release
  logic rst_meta_r;
  logic rst_sync_r;
  wire rst_n = rst_sync_r;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Pin synchronisers, two stages each
  logic [26:0] pin_meta_r;
  logic [26:0] pin_sync_r;
  wire [26:0] pin_raw = {cascade_select_inputs_in, if_width_strap_in, bus_in};

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= {3'h0, `SYNC_RESET_BUS};
      pin_sync_r <= {3'h0, `SYNC_RESET_BUS};
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  host_bus_t bus_s;
  wire strap_s = pin_sync_r[24];
  wire [1:0] cascade_s = pin_sync_r[26:25];
  assign bus_s = pin_sync_r[23:0];

  // Access strobes
  logic read_act_r;
  logic write_act_r;
  logic [`ADDR_W-1:0] rd_addr_r;
  logic [`ADDR_W-1:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data_r;

  wire read_act = ~bus_s.ce_n & ~bus_s.oe_n;
  wire write_act = ~bus_s.ce_n & ~bus_s.we_n & bus_s.oe_n;
  wire read_start = read_act & ~read_act_r;
  wire read_end = ~read_act & read_act_r;
  wire write_end = ~write_act & write_act_r;

  wire hit_cfg = (bus_s.addr == `DEVICE_CONFIGURATION_OFS);
  wire hit_ictl = (bus_s.addr == `INTERRUPT_CONTROL_OFS);
  wire hit_tog = (bus_s.addr == `PRESENCE_TOGGLE_OFS);
  wire hit_any = hit_cfg | hit_ictl | hit_tog;

  wire rd_was_tog = (rd_addr_r == `PRESENCE_TOGGLE_OFS);
  wire wr_cfg = write_end & normal_mode_in & (wr_addr_r == `DEVICE_CONFIGURATION_OFS);
  wire wr_ictl = write_end & normal_mode_in & (wr_addr_r == `INTERRUPT_CONTROL_OFS);

  // Register state
  logic [1:0] cascade_index_r;
  irq_ctrl_t ictl_r;
  logic toggle_r;
  irq_flags_t flags;
  logic irq_n;

  // Cascade index survives every mode change; only the pin reset clears it
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cascade_index_r <= `CFG_INDEX_RESET;
    end else if (wr_cfg) begin
      cascade_index_r <= wr_data_r[`CFG_INDEX_HI:`CFG_INDEX_LO];
    end
  end

  // Interrupt control returns to its reset value outside Normal mode
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ictl_r <= '0;
    end else if (!normal_mode_in) begin
      ictl_r <= '0;
    end else if (wr_ictl) begin
      ictl_r <= wr_data_r[`ICTL_CTRL_HI:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      toggle_r <= 1'b0;
    end else if (read_end & rd_was_tog & normal_mode_in) begin
      toggle_r <= ~toggle_r;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      read_act_r <= 1'b0;
      write_act_r <= 1'b0;
      rd_addr_r <= '0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
    end else begin
      read_act_r <= read_act;
      write_act_r <= write_act;
      if (read_start) begin
        rd_addr_r <= bus_s.addr;
      end
      if (write_act) begin
        wr_addr_r <= bus_s.addr;
        wr_data_r <= bus_s.data;
      end
    end
  end

  // Write-one clears of the two flags
  wire clear_ready = wr_ictl & wr_data_r[`ICTL_READY_FLAG_BIT];
  wire clear_violation = wr_ictl & wr_data_r[`ICTL_VIOL_FLAG_BIT];

  irq_event_unit u_irq (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .ctrl_in(ictl_r),
    .clear_ready_in(clear_ready),
    .clear_violation_in(clear_violation),
    .flash_ready_in(flash_ready_in),
    .prot_violation_in(prot_violation_in),
    .flags_out(flags),
    .irq_n_out(irq_n)
  );

  // Read views; reserved bits fixed
  wire [7:0] cfg_view = {strap_s, 1'b0, cascade_index_r, `CFG_LOW_NIBBLE};
  wire [7:0] ictl_view = {1'b0, flags.violation_flag, flags.ready_flag, ictl_r};
  wire [7:0] tog_view = `TOGGLE_FIXED | {5'h00, toggle_r, 2'h0};
  wire [7:0] read_mux = !normal_mode_in ? `READ_IDLE :
                        hit_cfg ? cfg_view :
                        hit_ictl ? ictl_view :
                        hit_tog ? tog_view : `READ_IDLE;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= `READ_IDLE;
    end else if (read_start) begin
      rd_data_r <= read_mux;
    end
  end

  assign data_out = rd_data_r;
  assign data_oe_out = read_act & read_act_r & hit_any;
  assign irq_n_out = irq_n;
  assign highest_cascade_index_out = cascade_index_r;
  // Boot blocks of devices up to the programmed index are mapped
  assign boot_block_mapped_out = (cascade_s <= cascade_index_r);

  // Helper state for checks
  logic ready_seen_r;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ready_seen_r <= 1'b0;
    end else begin
      ready_seen_r <= flash_ready_in;
    end
  end
  wire ready_rise = flash_ready_in & ~ready_seen_r;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  sequence s_cfg_read;
    read_start && hit_cfg && normal_mode_in;
  endsequence

  sequence s_pulse_low;
    ictl_r.pulse_mode && !irq_n_out && !ready_rise && !prot_violation_in &&
      $stable(ictl_r);
  endsequence

  sequence s_ready_armed;
    ready_rise && ictl_r.ready_trigger_select == `TRIG_ON_READY;
  endsequence

  sequence s_tog_read;
    read_start && hit_tog && normal_mode_in;
  endsequence

  a_strap_read_back: assert property (
    s_cfg_read |=> data_out[`CFG_STRAP_BIT] == $past(strap_s))
    else $error("strap bit not read back");

  a_index_write: assert property (
    wr_cfg |=> highest_cascade_index_out == $past(wr_data_r[`CFG_INDEX_HI:`CFG_INDEX_LO]))
    else $error("cascade index not written");

  a_index_kept_mode: assert property (
    !wr_cfg |=> $stable(highest_cascade_index_out))
    else $error("cascade index changed without write");

  a_reset_mode_zero: assert property (
    read_start && !normal_mode_in |=> data_out == `READ_IDLE)
    else $error("read outside Normal mode not zero");

  a_toggle_flips: assert property (
    read_end && rd_was_tog && normal_mode_in |=> toggle_r != $past(toggle_r))
    else $error("toggle bit did not flip");

  a_trig_off_quiet: assert property (
    ictl_r.ready_trigger_select == `TRIG_OFF |=> irq_n_out)
    else $error("output asserted while trigger off");

  a_ready_sets_flag: assert property (
    s_ready_armed |=> flags.ready_flag)
    else $error("ready flag not set");

  a_viol_sets_flag: assert property (
    prot_violation_in && ictl_r.violation_trigger_enable |=> flags.violation_flag)
    else $error("violation flag not set");

  a_level_holds: assert property (
    flags.ready_flag && !clear_ready && !ictl_r.pulse_mode &&
      ictl_r.ready_trigger_select != `TRIG_OFF |=> !irq_n_out)
    else $error("level output not held");

  a_pulse_one_cycle: assert property (
    s_pulse_low |=> irq_n_out)
    else $error("pulse longer than one cycle");

  a_clear_ready_flag: assert property (
    clear_ready && !(ready_rise && ictl_r.ready_trigger_select == `TRIG_ON_READY)
      |=> !flags.ready_flag)
    else $error("ready flag not cleared");

  a_set_beats_clear: assert property (
    clear_violation && prot_violation_in && ictl_r.violation_trigger_enable
      |=> flags.violation_flag ##1 1'b1)
    else $error("violation lost to clear");

  a_cfg_reserved_zero: assert property (
    s_cfg_read |=> !data_out[`CFG_RSVD_BIT])
    else $error("config reserved bit not zero");

  a_toggle_fixed_ones: assert property (
    s_tog_read |=> (data_out & `TOGGLE_FIXED) == `TOGGLE_FIXED)
    else $error("toggle reserved-one bits not set");

  a_toggle_read_value: assert property (
    s_tog_read |=> data_out[`TOGGLE_BIT] == $past(toggle_r))
    else $error("toggle bit not read back");

  a_pulse_on_set: assert property (
    ictl_r.pulse_mode && !flags.ready_flag && ready_rise &&
      ictl_r.ready_trigger_select == `TRIG_ON_READY |=> !irq_n_out)
    else $error("no pulse on new ready event");

  a_level_viol_holds: assert property (
    flags.violation_flag && !clear_violation && !ictl_r.pulse_mode &&
      ictl_r.ready_trigger_select != `TRIG_OFF |=> !irq_n_out)
    else $error("level output not held for violation");

  a_clear_viol_flag: assert property (
    clear_violation && !(prot_violation_in && ictl_r.violation_trigger_enable)
      |=> !flags.violation_flag)
    else $error("violation flag not cleared");

endmodule

`default_nettype wire

// [verif/host_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
  import host_regs_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Device answer
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  // Host pins
  output var host_bus_t bus_out
);
  initial begin
    bus_out = '{1'b1, 1'b1, 1'b1, 13'h0000, 8'h00};
  end

  // Strobes and gaps of six cycles clear the two-flop pin synchronisers
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk_in);
    bus_out.addr = a;
    bus_out.data = d;
    bus_out.ce_n = 1'b0;
    bus_out.we_n = 1'b0;
    repeat (6) @(negedge clk_in);
    bus_out.ce_n = 1'b1;
    bus_out.we_n = 1'b1;
    // Released data lines do not keep the last value
    bus_out.data = ~d;
    repeat (6) @(negedge clk_in);
  endtask

  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk_in);
    bus_out.addr = a;
    bus_out.ce_n = 1'b0;
    bus_out.oe_n = 1'b0;
    repeat (6) @(negedge clk_in);
    d = data_in;
    oe = data_oe_in;
    bus_out.ce_n = 1'b1;
    bus_out.oe_n = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask
endmodule

`default_nettype wire

// [verif/host_config_irq_registers_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module host_config_irq_registers_tb_top
  import host_regs_pkg::*;
;
  typedef struct {logic wr; logic [12:0] a; logic [7:0] d;} row_t;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  host_bus_t bus;
  logic [7:0] data_out;
  logic data_oe_out;
  logic strap = 1'b1;
  logic [1:0] casc = 2'h2;
  logic normal = 1'b1;
  logic fr = 1'b0;
  logic pv = 1'b0;
  logic irq_n;
  logic [1:0] idx;
  logic mapped;
  int fails = 0;
  int comparisons = 0;
  row_t rows[9];
  logic [7:0] d;
  logic oe;
  int n;

  host_config_irq_registers uut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .bus_in(bus),
    .data_out(data_out), .data_oe_out(data_oe_out), .if_width_strap_in(strap),
    .cascade_select_inputs_in(casc), .normal_mode_in(normal), .flash_ready_in(fr),
    .prot_violation_in(pv), .irq_n_out(irq_n), .highest_cascade_index_out(idx),
    .boot_block_mapped_out(mapped));

  host_bus_model host (.clk_in(mclk_in), .data_in(data_out), .data_oe_in(data_oe_out),
    .bus_out(bus));

  initial begin
    forever #10 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
    host.rd(a, d, oe);
    chk(d, exp);
  endtask

  // Counts low cycles of the interrupt output over eight cycles
  task automatic lows();
    n = 0;
    repeat (8) begin
      @(negedge mclk_in);
      if (irq_n === 1'b0) n++;
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge mclk_in);
    fails++;
    results();
  end

  initial begin
    rows = '{'{1'b0, 13'h100a, 8'h82}, '{1'b1, 13'h100a, 8'h30}, '{1'b0, 13'h100a, 8'hb2},
      '{1'b0, 13'h1046, 8'h82}, '{1'b0, 13'h1046, 8'h86}, '{1'b0, 13'h1046, 8'h82},
      '{1'b0, 13'h1000, 8'h00}, '{1'b1, 13'h100e, 8'h1f}, '{1'b0, 13'h100e, 8'h1f}};
    repeat (6) @(negedge mclk_in);
    chk({6'h00, irq_n, data_oe_out}, 8'h02);
    arst_n_in = 1'b1;
    repeat (6) @(negedge mclk_in);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        host.wr(rows[i].a, rows[i].d);
      end else begin
        host.rd(rows[i].a, d, oe);
        chk(d, rows[i].d);
        chk({7'h00, oe}, {7'h00, rows[i].a != 13'h1000});
      end
    end
    chk({5'h00, mapped, idx}, 8'h07);
    // Level mode, ready source
    host.wr(13'h100e, 8'h01);
    fr = 1'b1;
    repeat (3) @(negedge mclk_in);
    chk({7'h00, irq_n}, 8'h00);
    rdc(13'h100e, 8'h21);
    chk({7'h00, irq_n}, 8'h00);
    host.wr(13'h100e, 8'h21);
    chk({7'h00, irq_n}, 8'h01);
    fr = 1'b0;
    // Level mode, violation source
    host.wr(13'h100e, 8'h09);
    pv = 1'b1;
    @(negedge mclk_in);
    pv = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk({7'h00, irq_n}, 8'h00);
    rdc(13'h100e, 8'h49);
    host.wr(13'h100e, 8'h49);
    chk({7'h00, irq_n}, 8'h01);
    // Pulse mode gives exactly one low cycle
    host.wr(13'h100e, 8'h11);
    fr = 1'b1;
    lows();
    chk(8'(n), 8'h01);
    rdc(13'h100e, 8'h31);
    host.wr(13'h100e, 8'h31);
    fr = 1'b0;
    // Trigger off keeps the output negated
    host.wr(13'h100e, 8'h08);
    pv = 1'b1;
    @(negedge mclk_in);
    pv = 1'b0;
    lows();
    chk(8'(n), 8'h00);
    // Violation in the cycle its clear lands keeps the flag
    fork
      host.wr(13'h100e, 8'h48);
      begin
        repeat (9) @(negedge mclk_in);
        pv = 1'b1;
        @(negedge mclk_in);
        pv = 1'b0;
      end
    join
    rdc(13'h100e, 8'h48);
    // Outside Normal mode reads give zero and do not flip the toggle
    normal = 1'b0;
    rdc(13'h100a, 8'h00);
    rdc(13'h1046, 8'h00);
    normal = 1'b1;
    rdc(13'h1046, 8'h86);
    rdc(13'h100a, 8'hb2);
    strap = 1'b0;
    rdc(13'h100a, 8'h32);
    // Hardware reset in mid-run clears the index
    arst_n_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    chk({6'h00, irq_n, data_oe_out}, 8'h02);
    arst_n_in = 1'b1;
    repeat (6) @(negedge mclk_in);
    rdc(13'h100a, 8'h02);
    chk({5'h00, mapped, idx}, 8'h00);
    results();
  end
endmodule

`default_nettype wire
